// >>> rtl/rpl_rx_port_control.sv
/*
  receive port control for a two-input deserializer hub: register file
  behind the i2c target, lock/pass source selection, forwarding gates
  and two per-port lock/pass/equalizer engines.
  assumes an i2c target front end that hands over decoded register
  accesses (device address, offset, data, strobes) on clk_i, and
  link-side frame and error strobes already on clk_i.
*/
`timescale 1ns/1ps
`include "rpl_defines.svh"

module rpl_rx_port_control import rpl_pkg::*; #(
  parameter int EQ_W = 4,
  parameter int DWELL_CYCLES = `RPL_DWELL_TIME_NS / `RPL_CLK_PERIOD_NS,
  parameter int STABLE_CYCLES = `RPL_LOCK_STABLE_NS / `RPL_CLK_PERIOD_NS,
  parameter logic [6:0] DEV_ADDR = 7'h30 // arbitrary main address
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // decoded register access from the i2c target
  input wire logic [6:0] i2c_dev_addr_i,
  input wire logic i2c_remote_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_offset_i,
  input wire logic [7:0] reg_wdata_i,
  output logic reg_ack_o,
  output logic [7:0] reg_rdata_o,
  // digital reset request
  input wire logic digital_soft_reset_i,
  // link side, one bit per port
  input wire logic [1:0] link_signal_i,
  input wire logic [1:0] bit_err_i,
  input wire logic [1:0] frame_end_i,
  input wire logic [1:0] frame_size_ok_i,
  input wire logic [1:0] ser_pclk_active_i,
  input wire logic [1:0] ser_supported_i,
  input wire logic [1:0] video_valid_i,
  // status and control outputs
  output logic lock_o,
  output logic pass_o,
  output logic [1:0] port_lock_o,
  output logic [1:0] video_fwd_o,
  output logic [1:0] frame_trunc_o,
  output logic [1:0] rx_reset_o,
  output logic [1:0][EQ_W-1:0] eq_setting_o
);

  // shared registers
  logic [7:0] receive_port_control;
  logic [7:0] port_forwarding_control;
  logic [7:0] port_page_select;
  // per-port registers
  logic [1:0][7:0] equalizer_control_second;
  logic [1:0][7:0] equalizer_limits;
  logic [1:0][7:0] lock_pass_cfg;
  logic [1:0][6:0] port_i2c_addr;
  logic [1:0] lock_chg; // sticky lock change, cleared by read
  logic [1:0] lock_prev;
  logic [7:0] next_receive_port_control, next_port_forwarding_control, next_port_page_select;
  logic [1:0][7:0] next_equalizer_control_second, next_equalizer_limits, next_lock_pass_cfg;
  logic [1:0][6:0] next_port_i2c_addr;
  logic [1:0] next_lock_chg;
  logic [7:0] next_reg_rdata;
  logic next_lock_o, next_pass_o;
  // access decode
  logic main_hit;
  logic [1:0] port_hit;
  logic [1:0] wr_port;
  logic rd_sel;
  logic [1:0] eq_restart;
  // engine results
  logic [1:0] p_lock, p_pass, p_trunc, pin_lock;
  logic [1:0] port_en;

  // merge per-port indications by the 2-bit source code
  function automatic logic combine_src(input logic [1:0] sel, input logic [1:0] v,
                                       input logic [1:0] en);
    logic r;
    r = 1'b0;
    unique case (sel)
      2'b00: r = v[0];
      2'b01: r = v[1];
      2'b10: r = |(v & en);
      2'b11: r = (&(v | ~en)) & (|en);
    endcase
    return r;
  endfunction

  // address match: main address, or a programmed port address (zero = off)
  always_comb begin
    main_hit = (i2c_dev_addr_i == DEV_ADDR);
    for (int p = 0; p < 2; p++) begin
      port_hit[p] = !main_hit && (port_i2c_addr[p] != 7'h00)
                    && (i2c_dev_addr_i == port_i2c_addr[p]);
    end
    reg_ack_o = main_hit | (|port_hit);
    // main path is paged; a port address bypasses paging
    for (int p = 0; p < 2; p++) begin
      wr_port[p] = reg_wr_i && (main_hit ? port_page_select[p] : port_hit[p]);
      eq_restart[p] = digital_soft_reset_i
                      || (wr_port[p] && reg_offset_i == `RPL_REG_EQ_CONTROL
                          && reg_wdata_i[`RPL_EQ_RESTART_BIT]);
    end
    rd_sel = main_hit ? port_page_select[`RPL_PAGE_RD_BIT] : port_hit[1];
  end

  // register next values, read data and status merge
  always_comb begin
    next_receive_port_control = receive_port_control;
    next_port_forwarding_control = port_forwarding_control;
    next_port_page_select = port_page_select;
    next_equalizer_control_second = equalizer_control_second;
    next_equalizer_limits = equalizer_limits;
    next_lock_pass_cfg = lock_pass_cfg;
    next_port_i2c_addr = port_i2c_addr;
    next_reg_rdata = reg_rdata_o;
    next_lock_chg = lock_chg;
    // shared register writes on any matching path
    if (reg_wr_i && reg_ack_o) begin
      unique case (reg_offset_i)
        `RPL_REG_RX_PORT_CONTROL: begin
          // a remote controller cannot turn ports on or off
          if (!i2c_remote_i) begin
            next_receive_port_control = reg_wdata_i;
          end
        end
        `RPL_REG_FWD_CONTROL: next_port_forwarding_control = reg_wdata_i;
        `RPL_REG_PAGE_SELECT: next_port_page_select = reg_wdata_i;
        default: begin
        end
      endcase
    end
    // paged writes; restart bit is a strobe and never stored
    for (int p = 0; p < 2; p++) begin
      if (wr_port[p]) begin
        unique case (reg_offset_i)
          `RPL_REG_EQ_CONTROL: begin
            next_equalizer_control_second[p] = reg_wdata_i;
            next_equalizer_control_second[p][`RPL_EQ_RESTART_BIT] = 1'b0;
          end
          `RPL_REG_EQ_LIMITS: next_equalizer_limits[p] = reg_wdata_i;
          `RPL_REG_LOCK_PASS_CFG: next_lock_pass_cfg[p] = reg_wdata_i;
          `RPL_REG_PORT_I2C_ADDR: next_port_i2c_addr[p] = reg_wdata_i[6:0];
          default: begin
          end
        endcase
      end
    end
    // read mux; unmapped offsets read zero
    if (reg_rd_i && reg_ack_o) begin
      unique case (reg_offset_i)
        `RPL_REG_DEVICE_STATUS: next_reg_rdata = {6'h00, pass_o, lock_o};
        `RPL_REG_RX_PORT_CONTROL: next_reg_rdata = receive_port_control;
        `RPL_REG_FWD_CONTROL: next_reg_rdata = port_forwarding_control;
        `RPL_REG_PAGE_SELECT: next_reg_rdata = port_page_select;
        `RPL_REG_PORT_STATUS: begin
          // per-port lock, pass and sticky lock-change bits; the read clears the change bit
          next_reg_rdata = {5'h00, lock_chg[rd_sel], p_pass[rd_sel], p_lock[rd_sel]};
          next_lock_chg[rd_sel] = 1'b0;
        end
        `RPL_REG_EQ_CONTROL: next_reg_rdata = equalizer_control_second[rd_sel];
        `RPL_REG_EQ_STATUS: next_reg_rdata = 8'(eq_setting_o[rd_sel]);
        `RPL_REG_EQ_LIMITS: next_reg_rdata = equalizer_limits[rd_sel];
        `RPL_REG_LOCK_PASS_CFG: next_reg_rdata = lock_pass_cfg[rd_sel];
        `RPL_REG_PORT_I2C_ADDR: next_reg_rdata = {1'b0, port_i2c_addr[rd_sel]};
        default: next_reg_rdata = 8'h00;
      endcase
    end
    // a new change beats the read clear
    for (int p = 0; p < 2; p++) begin
      if (p_lock[p] != lock_prev[p]) begin
        next_lock_chg[p] = 1'b1;
      end
    end
    // pin lock depends on mode: 12-bit hf needs pixel clock
    port_en = receive_port_control[1:0];
    for (int p = 0; p < 2; p++) begin
      pin_lock[p] = p_lock[p]
                    && (!lock_pass_cfg[p][`RPL_CFG_HF12_BIT] || ser_pclk_active_i[p]);
    end
    next_lock_o = combine_src(receive_port_control[`RPL_CTL_LOCK_SEL_LSB +: 2],
                              pin_lock, port_en);
    next_pass_o = combine_src(receive_port_control[`RPL_CTL_PASS_SEL_LSB +: 2],
                              p_pass, port_en);
  end

  // registers; forwarding starts disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      receive_port_control <= `RPL_RST_RX_PORT_CONTROL;
      port_forwarding_control <= `RPL_RST_FWD_CONTROL;
      port_page_select <= `RPL_RST_PAGE_SELECT;
      equalizer_control_second <= {2{`RPL_RST_EQ_CONTROL}};
      equalizer_limits <= {2{`RPL_RST_EQ_LIMITS}};
      lock_pass_cfg <= {2{`RPL_RST_LOCK_PASS_CFG}};
      port_i2c_addr <= {2{7'(`RPL_RST_PORT_I2C_ADDR)}};
      lock_chg <= 2'b00;
      lock_prev <= 2'b00;
      reg_rdata_o <= 8'h00;
      lock_o <= 1'b0;
      pass_o <= 1'b0;
    end else begin
      receive_port_control <= next_receive_port_control;
      port_forwarding_control <= next_port_forwarding_control;
      port_page_select <= next_port_page_select;
      equalizer_control_second <= next_equalizer_control_second;
      equalizer_limits <= next_equalizer_limits;
      lock_pass_cfg <= next_lock_pass_cfg;
      port_i2c_addr <= next_port_i2c_addr;
      lock_chg <= next_lock_chg;
      lock_prev <= p_lock;
      reg_rdata_o <= next_reg_rdata;
      lock_o <= next_lock_o;
      pass_o <= next_pass_o;
    end
  end

  // forwarding gate: enable, lock, no truncation, optional pass hold
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      video_fwd_o[p] = video_valid_i[p] && port_forwarding_control[p]
                       && p_lock[p] && !p_trunc[p]
                       && (!lock_pass_cfg[p][`RPL_CFG_PASS_GATE_BIT] || p_pass[p]);
    end
    port_lock_o = p_lock;
    frame_trunc_o = p_trunc;
  end

  // one independent engine per port, all on clk_i
  for (genvar g = 0; g < 2; g++) begin : g_port
    rpl_port_engine #(
      .EQ_W(EQ_W),
      .DWELL_CYCLES(DWELL_CYCLES),
      .STABLE_CYCLES(STABLE_CYCLES)
    ) u_engine (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .port_en_i(receive_port_control[g]),
      .signal_pin_i(link_signal_i[g]),
      .bit_err_i(bit_err_i[g]),
      .frame_end_i(frame_end_i[g]),
      .frame_size_ok_i(frame_size_ok_i[g]),
      .ser_supported_i(ser_supported_i[g]),
      .err_count_en_i(lock_pass_cfg[g][`RPL_CFG_ERR_CNT_EN_BIT]),
      .pass_frames_i(lock_pass_cfg[g][`RPL_CFG_PASS_CNT_LSB +: 4]),
      .eq_ceiling_i(equalizer_limits[g][`RPL_LIM_CEIL_LSB +: EQ_W]),
      // next values, so a write that enables the floor and restarts starts at it
      .eq_floor_i(next_equalizer_limits[g][EQ_W-1:0]),
      .floor_en_i(next_equalizer_control_second[g][`RPL_EQ_FLOOR_EN_BIT]),
      .dwell_sel_i(equalizer_control_second[g][`RPL_EQ_DWELL_LSB +: 3]),
      .restart_i(eq_restart[g]),
      .first_restart_en_i(!lock_pass_cfg[g][`RPL_CFG_FIRST_RST_DIS_BIT]),
      .lock_o(p_lock[g]),
      .pass_o(p_pass[g]),
      .trunc_o(p_trunc[g]),
      .rx_reset_o(rx_reset_o[g]),
      .eq_o(eq_setting_o[g])
    );
  end

endmodule

// >>> rtl/rpl_defines.svh
/*
  register offsets, field positions, reset values and timing figures
  for the receive port lock/pass/equalizer control block.
  assumes a 40 MHz core clock; included by bare name from rtl/.
*/
`ifndef RPL_DEFINES_SVH
`define RPL_DEFINES_SVH

// shared registers
`define RPL_REG_DEVICE_STATUS 8'h04
`define RPL_REG_RX_PORT_CONTROL 8'h0c
`define RPL_REG_FWD_CONTROL 8'h20
`define RPL_REG_PAGE_SELECT 8'h4c
// per-port (paged) registers
`define RPL_REG_PORT_STATUS 8'h4d
`define RPL_REG_EQ_CONTROL 8'hd2
`define RPL_REG_EQ_STATUS 8'hd3
`define RPL_REG_EQ_LIMITS 8'hd5
`define RPL_REG_LOCK_PASS_CFG 8'hf0
`define RPL_REG_PORT_I2C_ADDR 8'hf8

// reset values
`define RPL_RST_RX_PORT_CONTROL 8'h03
`define RPL_RST_FWD_CONTROL 8'h00
`define RPL_RST_PAGE_SELECT 8'h01
`define RPL_RST_EQ_CONTROL 8'h60
`define RPL_RST_EQ_LIMITS 8'hf0
`define RPL_RST_LOCK_PASS_CFG 8'h20
`define RPL_RST_PORT_I2C_ADDR 8'h00

// field positions
`define RPL_CTL_LOCK_SEL_LSB 2
`define RPL_CTL_PASS_SEL_LSB 4
`define RPL_PAGE_RD_BIT 4
`define RPL_EQ_FLOOR_EN_BIT 2
`define RPL_EQ_RESTART_BIT 3
`define RPL_EQ_DWELL_LSB 5
`define RPL_LIM_CEIL_LSB 4
`define RPL_CFG_ERR_CNT_EN_BIT 0
`define RPL_CFG_PASS_GATE_BIT 1
`define RPL_CFG_FIRST_RST_DIS_BIT 2
`define RPL_CFG_HF12_BIT 3
`define RPL_CFG_PASS_CNT_LSB 4
`define RPL_STS_LOCK_BIT 0
`define RPL_STS_PASS_BIT 1
`define RPL_STS_LOCK_CHG_BIT 2

// timing
`define RPL_CLK_PERIOD_NS 25
`define RPL_DWELL_TIME_NS 2620000
`define RPL_LOCK_STABLE_NS 10000
`define RPL_DWELL_DEFAULT_SEL 3
`define RPL_ERR_THRESH 4

`endif

// >>> rtl/rpl_pkg.sv
/*
  types shared by the receive port control block.
  assumes nothing beyond the defines header.
*/
package rpl_pkg;

  // lock detector states
  typedef enum logic [1:0] {
    RPL_LK_ACQUIRE = 2'b01,
    RPL_LK_LOCKED = 2'b10
  } rpl_lock_state_type;

  // equalizer search states
  typedef enum logic [1:0] {
    RPL_EQ_SEARCH = 2'b01,
    RPL_EQ_HOLD = 2'b10
  } rpl_eq_state_type;

endpackage

// >>> rtl/rpl_port_engine.sv
/*
  one receive port: signal synchroniser, lock detector, pass counter,
  errored-frame truncation and adaptive equalizer search.
  assumes bit_err_i and frame strobes come from logic on clk_i.
*/
`timescale 1ns/1ps
`include "rpl_defines.svh"

module rpl_port_engine import rpl_pkg::*; #(
  parameter int EQ_W = 4,
  parameter int DWELL_W = 24,
  parameter int DWELL_CYCLES = `RPL_DWELL_TIME_NS / `RPL_CLK_PERIOD_NS,
  parameter int STABLE_CYCLES = `RPL_LOCK_STABLE_NS / `RPL_CLK_PERIOD_NS,
  parameter int ERR_THRESH = `RPL_ERR_THRESH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link side
  input wire logic port_en_i,
  input wire logic signal_pin_i,
  input wire logic bit_err_i,
  input wire logic frame_end_i,
  input wire logic frame_size_ok_i,
  input wire logic ser_supported_i,
  // configuration
  input wire logic err_count_en_i,
  input wire logic [3:0] pass_frames_i,
  input wire logic [EQ_W-1:0] eq_ceiling_i,
  input wire logic [EQ_W-1:0] eq_floor_i,
  input wire logic floor_en_i,
  input wire logic [2:0] dwell_sel_i,
  input wire logic restart_i,
  input wire logic first_restart_en_i,
  // status
  output logic lock_o,
  output logic pass_o,
  output logic trunc_o,
  output logic rx_reset_o,
  output logic [EQ_W-1:0] eq_o
);

  logic [2:0] sync; // three-stage pin synchroniser
  logic sig_ok; // filtered signal-present level
  rpl_lock_state_type lk_state;
  rpl_eq_state_type eq_state;
  logic [15:0] stable_cnt; // time the signal has been steady
  logic [7:0] err_cnt; // bit errors while locked
  logic [3:0] frame_cnt; // consecutive valid frames
  logic frame_bad; // error seen in the current frame
  logic [DWELL_W-1:0] dwell_cnt;
  logic first_done; // one-shot restart already spent
  logic [2:0] next_sync;
  logic next_sig_ok, next_lock, next_pass, next_trunc, next_rx_reset, next_frame_bad;
  logic next_first_done;
  rpl_lock_state_type next_lk_state;
  rpl_eq_state_type next_eq_state;
  logic [15:0] next_stable_cnt;
  logic [7:0] next_err_cnt;
  logic [3:0] next_frame_cnt;
  logic [DWELL_W-1:0] next_dwell_cnt, dwell_len;
  logic [EQ_W-1:0] next_eq, eq_start, eq_step;
  logic lose, gain, do_restart;

  // next-state logic for the whole port
  always_comb begin
    next_sync = {sync[1:0], signal_pin_i};
    // a change counts once the second and third stages agree
    next_sig_ok = (sync[1] == sync[2]) ? sync[2] : sig_ok;
    next_lk_state = lk_state;
    next_stable_cnt = stable_cnt;
    next_err_cnt = err_cnt;
    next_lock = lock_o;
    next_rx_reset = 1'b0;
    lose = 1'b0;
    gain = 1'b0;
    unique case (lk_state)
      RPL_LK_ACQUIRE: begin
        // lock only after the recovered signal is steady
        if (port_en_i && sig_ok) begin
          next_stable_cnt = stable_cnt + 16'h0001;
          if (stable_cnt == 16'(STABLE_CYCLES - 1)) begin
            gain = 1'b1;
          end
        end else begin
          next_stable_cnt = 16'h0000;
        end
      end
      RPL_LK_LOCKED: begin
        if (bit_err_i && err_cnt != 8'hff) begin
          next_err_cnt = err_cnt + 8'h01;
        end
        // optional error counting can drop lock
        if (!port_en_i || !sig_ok || (err_count_en_i && err_cnt >= 8'(ERR_THRESH))) begin
          lose = 1'b1;
        end
      end
    endcase
    if (gain) begin
      next_lk_state = RPL_LK_LOCKED;
      next_lock = 1'b1;
      next_err_cnt = 8'h00;
    end
    if (lose) begin
      // receiver reset and lock algorithm rerun
      next_lk_state = RPL_LK_ACQUIRE;
      next_lock = 1'b0;
      next_rx_reset = 1'b1;
      next_stable_cnt = 16'h0000;
    end

    // pass counts valid frames; any loss starts over
    next_frame_bad = frame_bad | bit_err_i;
    next_frame_cnt = frame_cnt;
    next_pass = pass_o;
    if (frame_end_i) begin
      next_frame_bad = 1'b0;
      if (lock_o && !frame_bad && !bit_err_i && frame_size_ok_i) begin
        if (frame_cnt != 4'hf) begin
          next_frame_cnt = frame_cnt + 4'h1;
        end
        if (frame_cnt + 4'h1 >= pass_frames_i) begin
          next_pass = 1'b1;
        end
      end else begin
        next_frame_cnt = 4'h0;
        next_pass = 1'b0;
      end
    end
    if (lose || !lock_o) begin
      next_frame_cnt = 4'h0;
      next_pass = 1'b0;
    end

    // errored frame is cut short until a locked frame boundary
    next_trunc = trunc_o;
    if ((lock_o && bit_err_i) || lose) begin
      next_trunc = 1'b1;
    end else if (frame_end_i && lock_o) begin
      next_trunc = 1'b0;
    end

    // equalizer search
    eq_start = floor_en_i ? eq_floor_i : '0;
    eq_step = (eq_o >= eq_ceiling_i) ? eq_start : eq_o + 1'b1;
    dwell_len = DWELL_W'(DWELL_CYCLES >> `RPL_DWELL_DEFAULT_SEL) << dwell_sel_i;
    do_restart = restart_i;
    next_first_done = first_done;
    // one restart on the first lock from a supported serializer
    if (gain && first_restart_en_i && ser_supported_i && !first_done) begin
      do_restart = 1'b1;
      next_first_done = 1'b1;
    end
    next_eq_state = eq_state;
    next_eq = eq_o;
    next_dwell_cnt = dwell_cnt;
    if (do_restart) begin
      next_eq_state = RPL_EQ_SEARCH;
      next_eq = eq_start;
      next_dwell_cnt = '0;
    end else begin
      unique case (eq_state)
        RPL_EQ_SEARCH: begin
          // dwell on each trial setting, then test lock
          next_dwell_cnt = dwell_cnt + 1'b1;
          if (dwell_cnt >= dwell_len - 1'b1) begin
            next_dwell_cnt = '0;
            if (lock_o && !lose) begin
              next_eq_state = RPL_EQ_HOLD;
            end else begin
              next_eq = eq_step;
            end
          end
        end
        RPL_EQ_HOLD: begin
          // hold while lock persists, step on loss
          if (!lock_o || lose) begin
            next_eq_state = RPL_EQ_SEARCH;
            next_eq = eq_step;
            next_dwell_cnt = '0;
          end
        end
      endcase
    end
  end

  // registers of the port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync <= 3'h0;
      sig_ok <= 1'b0;
      lk_state <= RPL_LK_ACQUIRE;
      stable_cnt <= 16'h0000;
      err_cnt <= 8'h00;
      lock_o <= 1'b0;
      rx_reset_o <= 1'b0;
      frame_bad <= 1'b0;
      frame_cnt <= 4'h0;
      pass_o <= 1'b0;
      trunc_o <= 1'b0;
      first_done <= 1'b0;
      eq_state <= RPL_EQ_SEARCH; // search runs from power-on
      eq_o <= '0;
      dwell_cnt <= '0;
    end else begin
      sync <= next_sync;
      sig_ok <= next_sig_ok;
      lk_state <= next_lk_state;
      stable_cnt <= next_stable_cnt;
      err_cnt <= next_err_cnt;
      lock_o <= next_lock;
      rx_reset_o <= next_rx_reset;
      frame_bad <= next_frame_bad;
      frame_cnt <= next_frame_cnt;
      pass_o <= next_pass;
      trunc_o <= next_trunc;
      first_done <= next_first_done;
      eq_state <= next_eq_state;
      eq_o <= next_eq;
      dwell_cnt <= next_dwell_cnt;
    end
  end

endmodule

// >>> dv/rpl_checker_properties.sv
/* checker: timing relations on the receive port control ports.
   assumes clk_i with a synchronous active-high rst_i. */
`timescale 1ns/1ps
module rpl_checker #(
  parameter int EQ_W = 4,
  parameter logic [6:0] DEV_ADDR = 7'h30
) (
  // clock, reset and register access
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [6:0] i2c_dev_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_ack_o,
  input wire logic [7:0] reg_rdata_o,
  // link side and status
  input wire logic [1:0] link_signal_i,
  input wire logic [1:0] bit_err_i,
  input wire logic [1:0] frame_end_i,
  input wire logic [1:0] video_valid_i,
  input wire logic lock_o,
  input wire logic [1:0] port_lock_o,
  input wire logic [1:0] video_fwd_o,
  input wire logic [1:0] frame_trunc_o,
  input wire logic [1:0] rx_reset_o,
  input wire logic [1:0][EQ_W-1:0] eq_setting_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reset_quiet_a: assert property (
    $past(rst_i) |-> video_fwd_o == 2'b00 && eq_setting_o == '0)
    else $error("outputs not clear after reset");
  fwd_gate_a: assert property (
    video_fwd_o[0] |-> video_valid_i[0] && port_lock_o[0])
    else $error("forwarding without lock or video");
  lock_stable_a: assert property (
    $rose(port_lock_o[0]) |-> $past(link_signal_i[0], 5))
    else $error("lock rose without a steady signal");
  rx_reset_a: assert property (
    $fell(port_lock_o[0]) |-> ##[0:1] rx_reset_o[0] ##1 !rx_reset_o[0])
    else $error("no single receiver reset on lock loss");
  lock_src_a: assert property (
    lock_o |-> port_lock_o != 2'b00 || $past(port_lock_o) != 2'b00)
    else $error("lock pin high with no port locked");
  rdata_hold_a: assert property (
    !$past(rst_i) && !$past(reg_rd_i && reg_ack_o) |-> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  ack_main_a: assert property (
    i2c_dev_addr_i == DEV_ADDR |-> reg_ack_o)
    else $error("main address not acknowledged");
  trunc_set_a: assert property (
    bit_err_i[0] && port_lock_o[0] && !frame_end_i[0] |=> frame_trunc_o[0])
    else $error("errored frame not truncated");
endmodule

bind rpl_rx_port_control rpl_checker #(.EQ_W(EQ_W), .DEV_ADDR(DEV_ADDR)) chk (
  .clk_i, .rst_i, .i2c_dev_addr_i, .reg_rd_i, .reg_ack_o, .reg_rdata_o,
  .link_signal_i, .bit_err_i, .frame_end_i, .video_valid_i, .lock_o,
  .port_lock_o, .video_fwd_o, .frame_trunc_o, .rx_reset_o, .eq_setting_o);

// >>> dv/rpl_ser_model.sv
/* remote serializer model for both ports: signal, frames, errors.
   assumes the bench drives its controls on clk_i. */
`timescale 1ns/1ps
module rpl_ser_model (
  // clock and bench controls
  input wire logic clk_i,
  input wire logic [1:0] present_i,
  input wire logic [1:0] err_i,
  input wire logic [1:0] pclk_i,
  // link side toward the hub
  output logic [1:0] link_signal_o,
  output logic [1:0] bit_err_o,
  output logic [1:0] frame_end_o,
  output logic [1:0] frame_size_ok_o,
  output logic [1:0] pclk_active_o,
  output logic [1:0] supported_o,
  output logic [1:0] video_valid_o
);
  logic [3:0] cnt = 4'h0; // 16-cycle frames keep the pass count short
  always @(posedge clk_i) begin
    cnt <= cnt + 4'h1;
  end
  assign link_signal_o = present_i;
  assign bit_err_o = err_i & present_i; // errors only exist on a live link
  assign frame_end_o = present_i & {2{cnt == 4'hf}};
  assign frame_size_ok_o = 2'b11; // frames always the same size
  assign pclk_active_o = pclk_i & present_i;
  assign supported_o = 2'b11;
  assign video_valid_o = present_i & ~frame_end_o;
endmodule

// >>> dv/testbench.sv
/* bench: register, lock, pass, forwarding, equalizer, error tests.
   assumes the design, checker and serializer model are compiled. */
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic remote = 1'b0, wr = 1'b0, rd = 1'b0, sreset = 1'b0;
  logic [7:0] off = 8'h00, wdat = 8'h00;
  logic [6:0] dadr = 7'h30;
  logic [1:0] present = 2'b00, err = 2'b00, pclk = 2'b00;
  logic ack, lock, pass;
  logic [7:0] rdata;
  logic [1:0] plock, fwd, trunc, rxrst, sig, berr, fend, fok, pact, sup, vval;
  logic [1:0][3:0] eq;
  logic [7:0] t_off [6] = '{8'h0c, 8'h20, 8'h4c, 8'hd2, 8'hd5, 8'h77};
  logic [7:0] t_val [6] = '{8'h03, 8'h00, 8'h01, 8'h60, 8'hf0, 8'h00};
  int failures = 0, n_checks = 0;
  always #12.5 clk_i = ~clk_i;
  rpl_ser_model ser (.clk_i(clk_i), .present_i(present), .err_i(err), .pclk_i(pclk),
    .link_signal_o(sig), .bit_err_o(berr), .frame_end_o(fend), .frame_size_ok_o(fok),
    .pclk_active_o(pact), .supported_o(sup), .video_valid_o(vval));
  rpl_rx_port_control #(.DWELL_CYCLES(64), .STABLE_CYCLES(4)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .i2c_dev_addr_i(dadr), .i2c_remote_i(remote), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_offset_i(off), .reg_wdata_i(wdat), .reg_ack_o(ack),
    .reg_rdata_o(rdata), .digital_soft_reset_i(sreset), .link_signal_i(sig),
    .bit_err_i(berr), .frame_end_i(fend), .frame_size_ok_i(fok), .ser_pclk_active_i(pact),
    .ser_supported_i(sup), .video_valid_i(vval), .lock_o(lock), .pass_o(pass),
    .port_lock_o(plock), .video_fwd_o(fwd), .frame_trunc_o(trunc), .rx_reset_o(rxrst),
    .eq_setting_o(eq));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic r, input logic [7:0] o, input logic [7:0] d);
    @(posedge clk_i);
    remote <= r;
    wr <= 1'b1;
    off <= o;
    wdat <= d;
    @(posedge clk_i);
    wr <= 1'b0;
    remote <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] o, input logic [7:0] e);
    @(posedge clk_i);
    rd <= 1'b1;
    off <= o;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 chk(rdata & ((o == 8'h4d) ? 8'h01 : 8'hff), e);
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_i);
    failures++;
    end_of_test();
  end
  initial begin
    logic [3:0] mn, mx;
    logic lost, tr;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 6; k++) rd_chk(t_off[k], t_val[k]);
    wr_reg(1'b0, 8'hf8, 8'h45);
    wr_reg(1'b0, 8'h4c, 8'h10);
    dadr <= 7'h45;
    rd_chk(8'hf8, 8'h45);
    rd_chk(8'h0c, 8'h03);
    @(posedge clk_i);
    dadr <= 7'h30;
    wr_reg(1'b0, 8'h4c, 8'h01);
    $display("test registers done");
    @(posedge clk_i);
    present <= 2'b11;
    for (int i = 0; i < 60 && plock !== 2'b11; i++) idle(1);
    idle(2);
    chk({5'h0, plock, lock}, 8'h07);
    chk({7'h0, pass}, 8'h00);
    rd_chk(8'h4d, 8'h01);
    wr_reg(1'b1, 8'h0c, 8'h00);
    rd_chk(8'h0c, 8'h03);
    idle(50);
    chk({7'h0, pass}, 8'h01);
    chk({6'h0, fwd}, 8'h00);
    wr_reg(1'b0, 8'h20, 8'h01);
    idle(1);
    chk({6'h0, fwd}, {7'h0, vval[0]});
    $display("test lock and forwarding done");
    @(posedge clk_i);
    present <= 2'b01;
    idle(8);
    for (int s = 0; s < 4; s++) begin
      wr_reg(1'b0, 8'h0c, {2'b00, s[1:0], s[1:0], 2'b11});
      idle(3);
      chk({6'h0, lock, pass}, {6'h0, {2{~s[0]}}});
    end
    wr_reg(1'b0, 8'h0c, 8'h03);
    wr_reg(1'b0, 8'hf0, 8'h28);
    idle(3);
    chk({6'h0, lock, plock[0]}, 8'h01);
    @(posedge clk_i);
    pclk <= 2'b01;
    idle(3);
    chk({6'h0, lock, plock[0]}, 8'h03);
    $display("test sources and modes done");
    wr_reg(1'b0, 8'h4c, 8'h12);
    wr_reg(1'b0, 8'hd5, 8'h32);
    wr_reg(1'b0, 8'hd2, 8'h0c);
    rd_chk(8'hd3, 8'h02);
    mn = 4'hf;
    mx = 4'h0;
    for (int i = 0; i < 40; i++) begin
      idle(1);
      mn = (eq[1] < mn) ? eq[1] : mn;
      mx = (eq[1] > mx) ? eq[1] : mx;
    end
    chk({mx, mn}, 8'h32);
    for (int i = 0; i < 20 && eq[1] !== 4'h2; i++) idle(1);
    for (int i = 0; i < 20 && eq[1] !== 4'h3; i++) idle(1);
    @(posedge clk_i);
    sreset <= 1'b1;
    @(posedge clk_i);
    sreset <= 1'b0;
    #1 chk({4'h0, eq[1]}, 8'h02);
    $display("test equalizer done");
    wr_reg(1'b0, 8'h4c, 8'h01);
    wr_reg(1'b0, 8'hf0, 8'h21);
    lost = 1'b0;
    tr = 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_i);
      err <= (i < 8 && i % 2 == 0) ? 2'b01 : 2'b00;
      #1;
      lost = lost | !plock[0];
      tr = tr | trunc[0];
    end
    chk({6'h0, lost, tr}, 8'h03);
    for (int i = 0; i < 60 && plock[0] !== 1'b1; i++) idle(1);
    chk({6'h0, plock}, 8'h01);
    $display("test errors done");
    end_of_test();
  end
endmodule
